// ### rtl/led_seq_pkg.sv
// Contract
// - at power-up light the calibration LED for about 0.3 s
// - bus-failure LED red while no fieldbus communication is active
// - after a configuration change, alarm LED lit 0.3 to 1.5 s at power-up
// - data-exchange LED green while controller communication is active
// - ready: output LED short pulse every 1.2 s; uncalibrated: alarm 4 Hz; error: alarm lit
// - calibration LED lit and calib_active_flag set for the whole calibration
// - calibration LED off once zero calibration succeeds
// - failed zero calibration sets alarm_flag and blinks alarm LED at 1 Hz
// - calibrated with heat_request and set point: regulation_active_flag and heat LED on
// - calibration LED 1 Hz on fault clear or no line voltage, 4 Hz when blocked
// - supply voltage too low blinks calibration LED at its own distinct rate
// - heat LED 4 Hz when heating blocked, lit while heating executes
// - in control mode output LED brightness follows heating current
// - alarm LED 1 Hz config error, 4 Hz bad calibration, lit other errors
// - data-exchange LED blinks fast on name switches 0xFF, red on module error
// - bus-failure LED 2 Hz for 3 s without data exchange, green 2 Hz node flash
package led_seq_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_US = 25_000;
    localparam int unsigned TICK_CYCLES_DFLT = TICK_US * (CLK_HZ / 1_000_000);
    localparam int unsigned START_MS = 300;
    localparam int unsigned CFG_ALARM_MS = 600;
    localparam int unsigned PULSE_PERIOD_MS = 1200;
    localparam int unsigned PULSE_ON_MS = 50;
    localparam int unsigned NODX_MS = 3000;
    localparam int unsigned ACT_MS = 50;
    localparam logic [7:0] START_TICKS = 8'(START_MS * 1000 / TICK_US);
    localparam logic [7:0] CFG_ALARM_TICKS = 8'(CFG_ALARM_MS * 1000 / TICK_US);
    localparam logic [7:0] PULSE_PERIOD_TICKS = 8'(PULSE_PERIOD_MS * 1000 / TICK_US);
    localparam logic [7:0] PULSE_ON_TICKS = 8'(PULSE_ON_MS * 1000 / TICK_US);
    localparam logic [7:0] NODX_TICKS = 8'(NODX_MS * 1000 / TICK_US);
    localparam logic [7:0] ACT_TICKS = 8'(ACT_MS * 1000 / TICK_US);
    // blink half periods in ticks: 4 Hz, 2 Hz, 1 Hz, 0.5 Hz
    localparam int NUM_BLINK = 4;
    localparam int B4HZ = 0;
    localparam int B2HZ = 1;
    localparam int B1HZ = 2;
    localparam int BSLOW = 3;
    localparam logic [7:0] BLINK_HALF [0:NUM_BLINK-1] = '{8'h05, 8'h0A, 8'h14, 8'h28};
    localparam logic [15:0] SETPOINT_MIN = 16'h0028;
    localparam int NUM_PORTS = 2;
    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SETPOINT = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int CTRL_CALIB_REQ = 0;
    localparam int CTRL_HEAT_REQ = 1;
    localparam int CTRL_FAULT_CLR = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [15:0] SETPOINT_RESET = 16'h0000;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_CALIBRATED = 7;
    localparam int STAT_HEAT_BLOCKED = 8;
    localparam int STAT_CALIB_BLOCKED = 9;

    typedef enum logic [2:0] {
        ST_START,
        ST_UNCAL,
        ST_CALIB,
        ST_CAL_FAIL,
        ST_READY
    } seq_state_t;

    typedef struct packed {
        logic comm_active;
        logic data_exchange;
        logic dx_internal_error;
        logic name_switch_ff;
        logic node_flash;
        logic line_voltage_ok;
        logic supply_low;
        logic config_changed;
        logic config_error;
        logic calib_inhibit;
        logic calib_done;
        logic calib_fail;
        logic calib_wrong;
        logic device_error;
    } cond_t;

    typedef struct packed {
        logic regulation_active;
        logic alarm;
        logic calib_active;
    } flags_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } regbus_t;
endpackage

// ### rtl/status_led_calibration_sequencer.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
module status_led_calibration_sequencer
    import led_seq_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire regbus_t i_bus,
    input wire cond_t i_cond,
    input wire logic [7:0] i_heat_current,
    input wire logic [NUM_PORTS-1:0] i_link_up,
    input wire logic [NUM_PORTS-1:0] i_frame,
    output logic [15:0] o_rdata,
    output flags_t o_flags,
    output logic o_led_calib,
    output logic o_led_heat,
    output logic o_led_output,
    output logic o_led_alarm,
    output logic o_led_dx_green,
    output logic o_led_dx_red,
    output logic o_led_bf_red,
    output logic o_led_bf_green,
    output logic [NUM_PORTS-1:0] o_led_link,
    output logic [NUM_PORTS-1:0] o_led_act
);
    seq_state_t state;
    logic [2:0] ctrl;
    logic [15:0] setpoint;
    logic [23:0] tick_cnt;
    logic tick;
    logic [NUM_BLINK-1:0] blink;
    logic [7:0] start_cnt;
    logic [7:0] cfg_cnt;
    logic cfg_alarm;
    logic [7:0] pulse_cnt;
    logic [7:0] nodx_cnt;
    logic dx_seen;
    logic [7:0] pwm_cnt;
    logic calibrated;
    logic calib_blocked;
    logic heat_blocked;
    logic regulating;
    logic calib_req;
    logic heat_req;
    logic fault_clr;

    assign calib_req = ctrl[CTRL_CALIB_REQ];
    assign heat_req = ctrl[CTRL_HEAT_REQ];
    assign fault_clr = ctrl[CTRL_FAULT_CLR];

    // registers written by software
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl <= CTRL_RESET;
            setpoint <= SETPOINT_RESET;
        end else if (i_ce && i_bus.wr) begin
            if (i_bus.addr == ADDR_CTRL) begin
                ctrl <= i_bus.wdata[2:0];
            end
            if (i_bus.addr == ADDR_SETPOINT) begin
                setpoint <= i_bus.wdata;
            end
        end
    end

    // read data one cycle after the strobe, zero when unmapped or idle
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 16'h0000;
        end else if (i_ce) begin
            o_rdata <= 16'h0000;
            if (i_bus.rd) begin
                case (i_bus.addr)
                    ADDR_CTRL: o_rdata <= {13'h0000, ctrl};
                    ADDR_SETPOINT: o_rdata <= setpoint;
                    ADDR_STATUS: begin
                        o_rdata[2:0] <= o_flags;
                        o_rdata[STAT_STATE_LSB +: 3] <= state;
                        o_rdata[STAT_CALIBRATED] <= calibrated;
                        o_rdata[STAT_HEAT_BLOCKED] <= heat_blocked;
                        o_rdata[STAT_CALIB_BLOCKED] <= calib_blocked;
                    end
                    default: o_rdata <= 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_cnt <= 24'h000000;
            tick <= 1'b0;
        end else if (i_ce) begin
            tick <= 1'b0;
            if (tick_cnt >= 24'(TICK_CYCLES - 1)) begin
                tick_cnt <= 24'h000000;
                tick <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 24'h000001;
            end
        end
    end

    for (genvar b = 0; b < NUM_BLINK; b++) begin : g_blink
        logic [7:0] half_cnt;
        always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                half_cnt <= 8'h00;
                blink[b] <= 1'b0;
            end else if (i_ce && tick) begin
                if (half_cnt >= BLINK_HALF[b] - 8'h01) begin
                    half_cnt <= 8'h00;
                    blink[b] <= ~blink[b];
                end else begin
                    half_cnt <= half_cnt + 8'h01;
                end
            end
        end
    end

    // power-up windows; counters saturate so they never rearm
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            start_cnt <= 8'h00;
            cfg_cnt <= 8'h00;
        end else if (i_ce && tick) begin
            if (start_cnt != 8'hFF) begin
                start_cnt <= start_cnt + 8'h01;
            end
            if (cfg_cnt != 8'hFF) begin
                cfg_cnt <= cfg_cnt + 8'h01;
            end
        end
    end
    // alarm window after a configuration change
    assign cfg_alarm = i_cond.config_changed && (cfg_cnt < CFG_ALARM_TICKS);

    // blocking conditions
    assign calib_blocked = heat_req || fault_clr || i_cond.calib_inhibit
        || !i_cond.line_voltage_ok || i_cond.config_error;
    assign heat_blocked = !calibrated || (state == ST_CALIB) || (setpoint < SETPOINT_MIN)
        || fault_clr || i_cond.device_error;
    // heating only once calibrated with a valid set point
    assign regulating = (state == ST_READY) && heat_req && !heat_blocked;

    // start-up and calibration sequence
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_START;
            calibrated <= 1'b0;
        end else if (i_ce) begin
            case (state)
                ST_START: begin
                    if (tick && start_cnt >= START_TICKS - 8'h01) begin
                        state <= ST_UNCAL;
                    end
                end
                ST_UNCAL, ST_READY: begin
                    if (calib_req && !calib_blocked) begin
                        state <= ST_CALIB;
                        calibrated <= 1'b0;
                    end
                end
                ST_CALIB: begin
                    if (i_cond.calib_fail) begin
                        state <= ST_CAL_FAIL;
                    end else if (i_cond.calib_done) begin
                        state <= ST_READY;
                        calibrated <= 1'b1;
                    end
                end
                ST_CAL_FAIL: begin
                    if (fault_clr) begin
                        state <= ST_UNCAL;
                    end else if (calib_req && !calib_blocked) begin
                        state <= ST_CALIB;
                    end
                end
                default: state <= ST_START;
            endcase
        end
    end

    // status flags
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flags <= '0;
        end else if (i_ce) begin
            o_flags.calib_active <= (state == ST_CALIB);
            o_flags.alarm <= (state == ST_CAL_FAIL) || i_cond.device_error
                || i_cond.config_error || i_cond.calib_wrong;
            o_flags.regulation_active <= regulating;
        end
    end

    // calibration LED, most specific condition first
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_led_calib <= 1'b0;
        end else if (i_ce) begin
            if (state == ST_START || state == ST_CALIB) begin
                o_led_calib <= 1'b1;
            end else if (i_cond.supply_low) begin
                o_led_calib <= blink[BSLOW];
            end else if (fault_clr || !i_cond.line_voltage_ok) begin
                o_led_calib <= blink[B1HZ];
            end else if (calib_req && calib_blocked) begin
                o_led_calib <= blink[B4HZ];
            end else begin
                o_led_calib <= 1'b0;
            end
        end
    end

    // heat LED
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_led_heat <= 1'b0;
        end else if (i_ce) begin
            if (regulating) begin
                o_led_heat <= 1'b1;
            end else if (heat_req && state != ST_START) begin
                o_led_heat <= blink[B4HZ];
            end else begin
                o_led_heat <= 1'b0;
            end
        end
    end

    // alarm LED
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_led_alarm <= 1'b0;
        end else if (i_ce) begin
            if (state == ST_START) begin
                o_led_alarm <= cfg_alarm;
            end else if (i_cond.device_error) begin
                o_led_alarm <= 1'b1;
            end else if (i_cond.config_error || state == ST_CAL_FAIL) begin
                o_led_alarm <= blink[B1HZ];
            end else if (i_cond.calib_wrong || state == ST_UNCAL) begin
                o_led_alarm <= blink[B4HZ];
            end else begin
                o_led_alarm <= cfg_alarm;
            end
        end
    end

    // output LED: idle heartbeat or current-proportional dimming
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pulse_cnt <= 8'h00;
            pwm_cnt <= 8'h00;
            o_led_output <= 1'b0;
        end else if (i_ce) begin
            pwm_cnt <= pwm_cnt + 8'h01;
            if (tick) begin
                pulse_cnt <= (pulse_cnt >= PULSE_PERIOD_TICKS - 8'h01) ? 8'h00
                    : pulse_cnt + 8'h01;
            end
            if (regulating) begin
                o_led_output <= (pwm_cnt < i_heat_current);
            end else if (state == ST_READY && !o_flags.alarm) begin
                o_led_output <= (pulse_cnt < PULSE_ON_TICKS);
            end else begin
                // off when uncalibrated or in error
                o_led_output <= 1'b0;
            end
        end
    end

    // data-exchange LED
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_led_dx_green <= 1'b0;
            o_led_dx_red <= 1'b0;
        end else if (i_ce) begin
            o_led_dx_red <= i_cond.dx_internal_error
                || (i_cond.name_switch_ff && blink[B4HZ]);
            o_led_dx_green <= i_cond.comm_active && !i_cond.dx_internal_error
                && !i_cond.name_switch_ff;
        end
    end

    // no-exchange window: armed when exchange drops after it had run
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            nodx_cnt <= 8'h00;
            dx_seen <= 1'b0;
        end else if (i_ce) begin
            dx_seen <= i_cond.data_exchange;
            if (dx_seen && !i_cond.data_exchange) begin
                nodx_cnt <= NODX_TICKS;
            end else if (tick && nodx_cnt != 8'h00) begin
                nodx_cnt <= nodx_cnt - 8'h01;
            end
        end
    end

    // bus-failure LED
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_led_bf_red <= 1'b1;
            o_led_bf_green <= 1'b0;
        end else if (i_ce) begin
            // red without communication, 2 Hz after exchange loss
            o_led_bf_red <= !i_cond.comm_active || (nodx_cnt != 8'h00 && blink[B2HZ]);
            o_led_bf_green <= i_cond.comm_active && i_cond.node_flash && blink[B2HZ];
        end
    end

    // per-port link and activity LEDs
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic [7:0] act_cnt;
        always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                act_cnt <= 8'h00;
                o_led_link[p] <= 1'b0;
                o_led_act[p] <= 1'b0;
            end else if (i_ce) begin
                // link lit, activity stretched so short frames stay visible
                o_led_link[p] <= i_link_up[p];
                if (i_frame[p]) begin
                    act_cnt <= ACT_TICKS;
                end else if (tick && act_cnt != 8'h00) begin
                    act_cnt <= act_cnt - 8'h01;
                end
                o_led_act[p] <= i_frame[p] || act_cnt != 8'h00;
            end
        end
    end

    a_startup_calib_led: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == ST_START && i_ce) |=> o_led_calib)
        else $error("calibration LED dark during start-up");

    a_bus_fail_red: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (!i_cond.comm_active && i_ce) |=> o_led_bf_red)
        else $error("bus-failure LED not red without communication");

    a_dx_green_on: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_cond.comm_active && !i_cond.dx_internal_error && !i_cond.name_switch_ff && i_ce)
        |=> o_led_dx_green)
        else $error("data-exchange LED not green while communicating");

    a_uncal_output_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == ST_UNCAL && i_ce) |=> !o_led_output)
        else $error("output LED lit while uncalibrated");

    a_calib_flag_led: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == ST_CALIB && i_ce) |=> (o_flags.calib_active && o_led_calib))
        else $error("calibration flag or LED missing during calibration");

    a_calib_success: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == ST_CALIB && i_cond.calib_done && !i_cond.calib_fail && i_ce)
        |=> (state == ST_READY && calibrated))
        else $error("successful calibration not taken");

    a_fail_alarm: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == ST_CAL_FAIL && i_ce) |=> o_flags.alarm)
        else $error("alarm flag missing after failed calibration");

    a_regulation_heat: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (regulating && i_ce) |=> (o_flags.regulation_active && o_led_heat))
        else $error("regulation flag or heat LED missing");

    a_activity_flash: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_frame[0] && i_ce) |=> o_led_act[0])
        else $error("activity LED did not flash on a frame");
endmodule

// ### bench/plc_model.sv
module plc_model
    import led_seq_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic [15:0] i_rdata,
    output regbus_t o_bus
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_bus = '0;
    end

    task automatic write(input logic [3:0] addr, input logic [15:0] data);
        @(posedge i_sys_clk);
        o_bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge i_sys_clk);
        o_bus <= '0;
    endtask

    task automatic read(input logic [3:0] addr, output logic [15:0] data);
        @(posedge i_sys_clk);
        o_bus <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_sys_clk);
        o_bus <= '0;
        @(posedge i_sys_clk);
        data = i_rdata;
    endtask
endmodule

// ### bench/test_status_led_calibration_sequencer.sv
module test_status_led_calibration_sequencer
    import led_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short tick keeps blink periods a few hundred cycles
    localparam int unsigned TICK = 20;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    cond_t cond = '0;
    logic [7:0] heat_cur = 8'h00;
    logic [1:0] link_up = 2'h1;
    logic [1:0] frame = 2'h0;
    regbus_t bus;
    logic [15:0] rdata;
    flags_t flags;
    logic led_calib, led_heat, led_output, led_alarm, dx_green, dx_red, bf_red, bf_green;
    logic [1:0] led_link, led_act;
    logic [6:0] leds;
    logic ce = 1'b1;
    logic [15:0] rd;
    int sel = 0;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #2.5 i_sys_clk = ~i_sys_clk;
    assign leds = {bf_green, bf_red, dx_red, led_output, led_heat, led_alarm, led_calib};

    plc_model plc (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_bus(bus));

    status_led_calibration_sequencer #(.TICK_CYCLES(TICK)) dut (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_ce(ce), .i_bus(bus),
        .i_cond(cond), .i_heat_current(heat_cur), .i_link_up(link_up), .i_frame(frame),
        .o_rdata(rdata), .o_flags(flags), .o_led_calib(led_calib), .o_led_heat(led_heat),
        .o_led_output(led_output), .o_led_alarm(led_alarm), .o_led_dx_green(dx_green),
        .o_led_dx_red(dx_red), .o_led_bf_red(bf_red), .o_led_bf_green(bf_green),
        .o_led_link(led_link), .o_led_act(led_act));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // length of one lit run of the chosen LED
    task automatic lit_run(input int which, input int exp);
        int len;
        len = 0;
        sel = which;
        while (leds[sel] !== 1'b1 && len < 2000) begin
            wait_cyc(1);
            len++;
        end
        while (leds[sel] !== 1'b0 && len < 4000) begin
            wait_cyc(1);
            len++;
            if (len > 2000) len = 4000;
        end
        wait_cyc(1);
        len = 0;
        while (leds[sel] !== 1'b1 && len < 2000) begin
            wait_cyc(1);
            len++;
        end
        len = 0;
        while (leds[sel] === 1'b1 && len < 2000) begin
            wait_cyc(1);
            len++;
        end
        check(16'(len), 16'(exp));
    endtask

    task automatic test_power_up();
        cond.config_changed <= 1'b1;
        cond.line_voltage_ok <= 1'b1;
        wait_cyc(3);
        check(16'(bf_red), 16'h0001);
        i_reset_n <= 1'b1;
        wait_cyc(5);
        check(16'(led_calib), 16'h0001);
        check(16'(led_alarm), 16'h0001);
        check(16'(led_link), 16'h0001);
        wait_cyc(600);
        plc.read(ADDR_STATUS, rd);
        check(16'(rd[6:4]), 16'h0001);
        lit_run(1, 5 * TICK);
    endtask

    task automatic test_comm_and_calib();
        cond.comm_active <= 1'b1;
        cond.data_exchange <= 1'b1;
        wait_cyc(3);
        check(16'({bf_red, dx_green}), 16'h0001);
        plc.write(ADDR_CTRL, 16'h0001);
        wait_cyc(4);
        check(16'({led_calib, flags.calib_active}), 16'h0003);
        plc.write(ADDR_CTRL, 16'h0000);
        cond.calib_done <= 1'b1;
        wait_cyc(1);
        cond.calib_done <= 1'b0;
        wait_cyc(3);
        check(16'({led_calib, flags.calib_active}), 16'h0000);
        plc.read(ADDR_STATUS, rd);
        check(16'(rd[6:4]), 16'h0004);
    endtask

    task automatic test_heat();
        plc.write(ADDR_CTRL, 16'h0000);
        plc.write(ADDR_SETPOINT, 16'h0064);
        lit_run(3, 2 * TICK);
        heat_cur <= 8'h40;
        plc.write(ADDR_CTRL, 16'h0002);
        wait_cyc(4);
        check(16'({flags.regulation_active, led_heat}), 16'h0003);
        lit_run(3, 'h40);
        plc.write(ADDR_SETPOINT, 16'h0010);
        lit_run(2, 5 * TICK);
        plc.write(ADDR_CTRL, 16'h0000);
    endtask

    task automatic test_bus_leds();
        cond.name_switch_ff <= 1'b1;
        lit_run(4, 5 * TICK);
        check(16'(dx_green), 16'h0000);
        cond.name_switch_ff <= 1'b0;
        cond.dx_internal_error <= 1'b1;
        wait_cyc(3);
        check(16'({dx_red, dx_green}), 16'h0002);
        cond.dx_internal_error <= 1'b0;
        cond.data_exchange <= 1'b0;
        lit_run(5, 10 * TICK);
        cond.node_flash <= 1'b1;
        lit_run(6, 10 * TICK);
        cond.node_flash <= 1'b0;
        wait_cyc(1500);
        check(16'({bf_red, bf_green}), 16'h0000);
        frame <= 2'h1;
        wait_cyc(1);
        frame <= 2'h0;
        wait_cyc(2);
        check(16'(led_act), 16'h0001);
        wait_cyc(80);
        check(16'(led_act), 16'h0000);
    endtask

    task automatic test_fail_and_clear();
        plc.write(ADDR_CTRL, 16'h0001);
        wait_cyc(4);
        plc.write(ADDR_CTRL, 16'h0000);
        cond.calib_fail <= 1'b1;
        wait_cyc(1);
        cond.calib_fail <= 1'b0;
        wait_cyc(3);
        check(16'(flags.alarm), 16'h0001);
        lit_run(1, 20 * TICK);
        plc.write(ADDR_CTRL, 16'h0004);
        lit_run(0, 20 * TICK);
        plc.write(ADDR_CTRL, 16'h0000);
        plc.read(4'hC, rd);
        check(rd, 16'h0000);
    endtask

    task automatic test_undervoltage();
        cond.supply_low <= 1'b1;
        lit_run(0, 40 * TICK);
        ce <= 1'b0;
        wait_cyc(2);
        rd = 16'(leds);
        wait_cyc(900);
        check(16'(leds), rd);
        ce <= 1'b1;
        cond.config_error <= 1'b1;
        lit_run(1, 20 * TICK);
        cond.device_error <= 1'b1;
        wait_cyc(3);
        check(16'({led_alarm, flags.alarm}), 16'h0003);
    endtask

    initial begin
        test_power_up();
        test_comm_and_calib();
        test_heat();
        test_bus_leds();
        test_fail_and_clear();
        test_undervoltage();
        summarize();
    end
endmodule
